// file: shared/cfg_fuse_pkg.sv
// Purpose: Constants and carriers for the configuration byte decoder
// Assumes: Byte-wide configuration space behind a plain register port
// Notes:   Offsets are byte addresses within configuration space
package cfg_fuse_pkg;

    localparam logic [21:0] OFF_BUS_WAIT_MODE  = 22'h30_0004;
    localparam logic [21:0] OFF_PIN_MUX_RESET  = 22'h30_0005;
    localparam logic [21:0] OFF_DEBUG_PROG     = 22'h30_0006;
    localparam logic [21:0] OFF_CP_BLOCKS      = 22'h30_0008;
    localparam logic [21:0] OFF_CP_BOOT_EE     = 22'h30_0009;
    localparam logic [21:0] OFF_WP_BLOCKS      = 22'h30_000a;
    localparam logic [21:0] OFF_WP_BOOT_EE_CFG = 22'h30_000b;
    localparam logic [21:0] OFF_TRP_BLOCKS     = 22'h30_000c;
    localparam logic [21:0] OFF_TRP_BOOT       = 22'h30_000d;
    localparam logic [21:0] OFF_ID_LOW         = 22'h3f_fffe;
    localparam logic [21:0] OFF_ID_HIGH        = 22'h3f_ffff;

    // Implemented-bit masks; other bits read zero
    localparam logic [7:0] MASK_BUS_WAIT_MODE  = 8'h83;
    localparam logic [7:0] MASK_PIN_MUX_RESET  = 8'h83;
    localparam logic [7:0] MASK_DEBUG_PROG     = 8'h85;
    localparam logic [7:0] MASK_BLOCKS         = 8'h0f;
    localparam logic [7:0] MASK_BOOT_EE        = 8'hc0;
    localparam logic [7:0] MASK_WP_BOOT_EE_CFG = 8'he0;
    localparam logic [7:0] MASK_TRP_BOOT       = 8'h40;

    // Unprogrammed value is all ones on implemented bits
    localparam logic [7:0] RST_ERASED = 8'hff;

    localparam int BIT_WAIT_EN   = 7;
    localparam int BIT_RST_PIN   = 7;
    localparam int BIT_ENH_MUX   = 1;
    localparam int BIT_CCP2_MUX  = 0;
    localparam int BIT_DEBUG     = 7;
    localparam int BIT_LV_PROG   = 2;
    localparam int BIT_STACK_RST = 0;
    localparam int BIT_EEPROM    = 7;
    localparam int BIT_BOOT      = 6;
    localparam int BIT_CONFIG    = 5;

    localparam logic [21:0] BOOT_END   = 22'h00_07ff;
    localparam logic [21:0] PROG_END   = 22'h00_ffff;
    localparam logic [21:0] CFG_START  = 22'h30_0000;
    localparam logic [21:0] CFG_END    = 22'h30_00ff;

    // Arbitrary identity values
    localparam logic [7:0] ID_PART_LOW  = 8'h00;
    localparam logic [7:0] ID_PART_HIGH = 8'h00;

    typedef enum logic [1:0]
    {
        MODE_EXT_MCU   = 2'h0,
        MODE_MPU_BOOT  = 2'h1,
        MODE_MPU       = 2'h2,
        MODE_MCU       = 2'h3
    } proc_mode_e;

    typedef enum logic [1:0]
    {
        CCP2_ON_PORT_C1,
        CCP2_ON_PORT_E7,
        CCP2_ON_PORT_B3
    } ccp2_pin_e;

    typedef struct packed
    {
        logic [7:0] bus_wait_processor_mode_cfg;
        logic [7:0] pin_mux_reset_cfg;
        logic [7:0] debug_prog_stack_cfg;
        logic [7:0] code_protect_blocks;
        logic [7:0] code_protect_boot_eeprom;
        logic [7:0] write_protect_blocks;
        logic [7:0] write_protect_boot_eeprom_cfg;
        logic [7:0] table_read_protect_blocks;
        logic [7:0] table_read_protect_boot;
    } cfg_bytes_s;

    typedef struct packed
    {
        proc_mode_e mode;
        logic       table_wait_apply;
        logic       reset_pin_is_reset;
        logic       port_g_pin5_is_input;
        logic       enh_pwm_on_port_e;
        ccp2_pin_e  ccp2_pin;
        logic       debug_pins_dedicated;
        logic       low_volt_prog_enable;
        logic       stack_fault_reset_enable;
    } cfg_decode_s;

    typedef struct packed
    {
        logic        valid;
        logic        is_write;
        logic [21:0] target;
        logic [21:0] exec_addr;
        logic        eeprom;
    } access_req_s;

    typedef struct packed
    {
        logic allow;
        logic read_masked;
    } access_ans_s;

endpackage

// file: rtl/config_fuse_decode_protect.sv
// Overview of operation
// - Wait enable set: table access ignores wait field; clear: wait field applies.
// - Mode field: 11 controller, 10 processor, 01 processor with boot, 00 extended.
// - Reset pin enable set: pin is active-low reset; clear: general input, no reset.
// - Enhanced PWM mux: 1 routes B/C outputs to port E 6..3, 0 to port H 7..4.
// - Controller mode: module 2 on port C pin 1 if set, else port E pin 7.
// - Other modes: module 2 on port C pin 1 if set, else port B pin 3.
// - Debugger bit set: debugger off, port B 6/7 general; clear: debug pins dedicated.
// - Bit 2 of debug byte enables low-voltage serial programming.
// - Stack fault reset enable set makes stack full or underflow reset the device.
// - Four code-protect bits protect program blocks 0 to 3 when cleared.
// - Boot-eeprom byte bit 7 protects eeprom, bit 6 protects boot block, when cleared.
// - Four write-protect bits block writes to program blocks 0 to 3 when cleared.
// - Write byte bit 7 guards eeprom writes, bit 6 guards boot writes, when cleared.
// - Write byte bit 5 cleared blocks writes to configuration range 300000-3000FF.
// - Table-read protect bits stop reads of a block from code in other blocks.
// - Read-only identity: 3-bit part field, 8-bit part field and revision field.
// - Unimplemented configuration bits read as zero; block 3 bits read one when HAS_BLOCK3 is clear.
//
// Purpose: Holds the configuration bytes and decodes mode, pin routing and protection
// Assumes: Programmer or table writes arrive as single-cycle byte writes
// Notes:   A one in a protect bit means unprotected; bytes come out of reset erased
`timescale 1ns/1ps
`default_nettype none

module config_fuse_decode_protect #(
    parameter logic [4:0] REVISION    = 5'h00, // Arbitrary
    parameter logic       HAS_BLOCK3  = 1'b1
)(
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    input  wire logic                      clk_en_in,
    input  wire logic [21:0]               reg_addr_in,
    input  wire logic [7:0]                reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic [7:0]                     reg_rdata_out,
    input  wire logic [1:0]                bus_wait_count_in,
    input  wire logic                      master_reset_n_in,
    input  wire logic                      port_g_pin5_in,
    input  wire logic                      stack_fault_in,
    input  wire cfg_fuse_pkg::access_req_s access_req_in,
    output cfg_fuse_pkg::access_ans_s      access_ans_out,
    output cfg_fuse_pkg::cfg_decode_s      decode_out,
    output logic [1:0]                     table_wait_out,
    output logic                           device_reset_out,
    output logic                           port_g_pin5_out,
    output logic                           port_c_pin1_ccp2_out,
    output logic                           port_e_pin7_ccp2_out,
    output logic                           port_b_pin3_ccp2_out,
    output logic [3:0]                     port_e_pwm_sel_out,
    output logic [3:0]                     port_h_pwm_sel_out,
    output logic [1:0]                     debug_pin_sel_out
);

    typedef struct packed
    {
        cfg_fuse_pkg::cfg_bytes_s  cfg;
        logic [7:0]                rdata;
        cfg_fuse_pkg::cfg_decode_s dec;
        cfg_fuse_pkg::access_ans_s ans;
        logic                      dev_rst;
    } state_s;

    state_s state_q;
    state_s state_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Block index: 0 boot, 1..4 program blocks 0..3, 5 outside program memory
    function automatic logic [2:0] block_of(input logic [21:0] addr);
        logic [2:0] idx;
        idx = 3'h5;
        if (addr <= cfg_fuse_pkg::BOOT_END)
            idx = 3'h0;
        else if (addr <= cfg_fuse_pkg::PROG_END)
            idx = 3'(addr[15:14]) + 3'h1;
        return idx;
    endfunction

    // Boot bit at index 0, block bits at 1..4
    function automatic logic [4:0] guard_bits(input logic [7:0] blocks,
                                              input logic [7:0] boot);
        return {blocks[3:0], boot[cfg_fuse_pkg::BIT_BOOT]};
    endfunction

    function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
        return v & m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [7:0]  wr;
        logic [7:0]  blk_mask;
        logic [2:0]  tgt_blk;
        logic [2:0]  exe_blk;
        logic [4:0]  cp_g;
        logic [4:0]  wp_g;
        logic [4:0]  trp_g;
        logic        cfg_wr_ok;
        state_d  = state_q;
        wr       = reg_wdata_in;
        blk_mask = HAS_BLOCK3 ? cfg_fuse_pkg::MASK_BLOCKS : 8'h07;
        tgt_blk  = block_of(access_req_in.target);
        exe_blk  = block_of(access_req_in.exec_addr);
        cp_g     = guard_bits(state_q.cfg.code_protect_blocks,
                              state_q.cfg.code_protect_boot_eeprom);
        wp_g     = guard_bits(state_q.cfg.write_protect_blocks,
                              state_q.cfg.write_protect_boot_eeprom_cfg);
        trp_g    = guard_bits(state_q.cfg.table_read_protect_blocks,
                              state_q.cfg.table_read_protect_boot);
        cfg_wr_ok = state_q.cfg.write_protect_boot_eeprom_cfg[cfg_fuse_pkg::BIT_CONFIG];

        // Cell writes: the masked byte is stored as written, ones included; write protection holds the byte
        if (reg_wr_in && cfg_wr_ok)
        begin
            case (reg_addr_in)
                cfg_fuse_pkg::OFF_BUS_WAIT_MODE:
                    state_d.cfg.bus_wait_processor_mode_cfg =
                        masked(wr, cfg_fuse_pkg::MASK_BUS_WAIT_MODE);
                cfg_fuse_pkg::OFF_PIN_MUX_RESET:
                    state_d.cfg.pin_mux_reset_cfg = masked(wr, cfg_fuse_pkg::MASK_PIN_MUX_RESET);
                cfg_fuse_pkg::OFF_DEBUG_PROG:
                    state_d.cfg.debug_prog_stack_cfg = masked(wr, cfg_fuse_pkg::MASK_DEBUG_PROG);
                cfg_fuse_pkg::OFF_CP_BLOCKS:
                    state_d.cfg.code_protect_blocks = masked(wr, blk_mask) | ~blk_mask
                        & cfg_fuse_pkg::MASK_BLOCKS;
                cfg_fuse_pkg::OFF_CP_BOOT_EE:
                    state_d.cfg.code_protect_boot_eeprom = masked(wr, cfg_fuse_pkg::MASK_BOOT_EE);
                cfg_fuse_pkg::OFF_WP_BLOCKS:
                    state_d.cfg.write_protect_blocks = masked(wr, blk_mask) | ~blk_mask
                        & cfg_fuse_pkg::MASK_BLOCKS;
                cfg_fuse_pkg::OFF_WP_BOOT_EE_CFG:
                    state_d.cfg.write_protect_boot_eeprom_cfg =
                        masked(wr, cfg_fuse_pkg::MASK_WP_BOOT_EE_CFG);
                cfg_fuse_pkg::OFF_TRP_BLOCKS:
                    state_d.cfg.table_read_protect_blocks = masked(wr, blk_mask) | ~blk_mask
                        & cfg_fuse_pkg::MASK_BLOCKS;
                cfg_fuse_pkg::OFF_TRP_BOOT:
                    state_d.cfg.table_read_protect_boot = masked(wr, cfg_fuse_pkg::MASK_TRP_BOOT);
                default:
                    state_d.cfg = state_q.cfg;
            endcase
        end

        // Stored bytes already hold zeros in unimplemented bits
        state_d.rdata = 8'h00;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                cfg_fuse_pkg::OFF_BUS_WAIT_MODE:  state_d.rdata = state_q.cfg.bus_wait_processor_mode_cfg;
                cfg_fuse_pkg::OFF_PIN_MUX_RESET:  state_d.rdata = state_q.cfg.pin_mux_reset_cfg;
                cfg_fuse_pkg::OFF_DEBUG_PROG:     state_d.rdata = state_q.cfg.debug_prog_stack_cfg;
                cfg_fuse_pkg::OFF_CP_BLOCKS:      state_d.rdata = state_q.cfg.code_protect_blocks;
                cfg_fuse_pkg::OFF_CP_BOOT_EE:     state_d.rdata = state_q.cfg.code_protect_boot_eeprom;
                cfg_fuse_pkg::OFF_WP_BLOCKS:      state_d.rdata = state_q.cfg.write_protect_blocks;
                cfg_fuse_pkg::OFF_WP_BOOT_EE_CFG: state_d.rdata = state_q.cfg.write_protect_boot_eeprom_cfg;
                cfg_fuse_pkg::OFF_TRP_BLOCKS:     state_d.rdata = state_q.cfg.table_read_protect_blocks;
                cfg_fuse_pkg::OFF_TRP_BOOT:       state_d.rdata = state_q.cfg.table_read_protect_boot;
                cfg_fuse_pkg::OFF_ID_LOW:         state_d.rdata = {cfg_fuse_pkg::ID_PART_LOW[2:0],
                                                                   REVISION};
                cfg_fuse_pkg::OFF_ID_HIGH:        state_d.rdata = cfg_fuse_pkg::ID_PART_HIGH;
                default:                          state_d.rdata = 8'h00;
            endcase
        end

        // Decoded configuration, registered from the stored bytes
        state_d.dec.mode = cfg_fuse_pkg::proc_mode_e'(
            state_q.cfg.bus_wait_processor_mode_cfg[1:0]);
        state_d.dec.table_wait_apply =
            ~state_q.cfg.bus_wait_processor_mode_cfg[cfg_fuse_pkg::BIT_WAIT_EN];
        state_d.dec.reset_pin_is_reset =
            state_q.cfg.pin_mux_reset_cfg[cfg_fuse_pkg::BIT_RST_PIN];
        state_d.dec.port_g_pin5_is_input =
            ~state_q.cfg.pin_mux_reset_cfg[cfg_fuse_pkg::BIT_RST_PIN];
        state_d.dec.enh_pwm_on_port_e =
            state_q.cfg.pin_mux_reset_cfg[cfg_fuse_pkg::BIT_ENH_MUX];
        if (state_q.cfg.pin_mux_reset_cfg[cfg_fuse_pkg::BIT_CCP2_MUX])
            state_d.dec.ccp2_pin = cfg_fuse_pkg::CCP2_ON_PORT_C1;
        else if (state_d.dec.mode == cfg_fuse_pkg::MODE_MCU)
            state_d.dec.ccp2_pin = cfg_fuse_pkg::CCP2_ON_PORT_E7;
        else
            state_d.dec.ccp2_pin = cfg_fuse_pkg::CCP2_ON_PORT_B3;
        state_d.dec.debug_pins_dedicated =
            ~state_q.cfg.debug_prog_stack_cfg[cfg_fuse_pkg::BIT_DEBUG];
        state_d.dec.low_volt_prog_enable =
            state_q.cfg.debug_prog_stack_cfg[cfg_fuse_pkg::BIT_LV_PROG];
        state_d.dec.stack_fault_reset_enable =
            state_q.cfg.debug_prog_stack_cfg[cfg_fuse_pkg::BIT_STACK_RST];

        // Reset request from the reset pin or a stack fault
        state_d.dev_rst = (state_q.dec.reset_pin_is_reset && !master_reset_n_in)
                        || (state_q.dec.stack_fault_reset_enable && stack_fault_in);

        // Access check, answered one cycle after the request
        state_d.ans = '{allow: 1'b0, read_masked: 1'b0};
        if (access_req_in.valid)
        begin
            if (access_req_in.eeprom)
            begin
                if (access_req_in.is_write)
                    state_d.ans.allow =
                        state_q.cfg.write_protect_boot_eeprom_cfg[cfg_fuse_pkg::BIT_EEPROM];
                else
                    state_d.ans.allow =
                        state_q.cfg.code_protect_boot_eeprom[cfg_fuse_pkg::BIT_EEPROM];
            end
            else if (access_req_in.is_write)
            begin
                if (access_req_in.target >= cfg_fuse_pkg::CFG_START
                    && access_req_in.target <= cfg_fuse_pkg::CFG_END)
                    state_d.ans.allow = cfg_wr_ok;
                else if (tgt_blk == 3'h5)
                    state_d.ans.allow = 1'b1;
                else
                    state_d.ans.allow = wp_g[tgt_blk];
            end
            else if (tgt_blk == 3'h5 || exe_blk == tgt_blk)
                state_d.ans.allow = 1'b1;
            else
                state_d.ans.allow = trp_g[tgt_blk];
            state_d.ans.read_masked = !access_req_in.is_write && !access_req_in.eeprom
                && tgt_blk != 3'h5 && !cp_g[tgt_blk] && exe_blk != tgt_blk;
            if (state_d.ans.read_masked)
                state_d.ans.allow = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state_q.cfg   <= '{cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_BUS_WAIT_MODE,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_PIN_MUX_RESET,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_DEBUG_PROG,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_BLOCKS,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_BOOT_EE,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_BLOCKS,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_WP_BOOT_EE_CFG,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_BLOCKS,
                               cfg_fuse_pkg::RST_ERASED & cfg_fuse_pkg::MASK_TRP_BOOT};
            state_q.rdata <= 8'h00;
            state_q.dec   <= '{mode: cfg_fuse_pkg::MODE_MCU, table_wait_apply: 1'b0,
                               reset_pin_is_reset: 1'b1, port_g_pin5_is_input: 1'b0,
                               enh_pwm_on_port_e: 1'b1, ccp2_pin: cfg_fuse_pkg::CCP2_ON_PORT_C1,
                               debug_pins_dedicated: 1'b0, low_volt_prog_enable: 1'b1,
                               stack_fault_reset_enable: 1'b1};
            state_q.ans   <= '{allow: 1'b0, read_masked: 1'b0};
            state_q.dev_rst <= 1'b0;
        end
        else if (clk_en_in)
            state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata_out    = state_q.rdata;
    assign access_ans_out   = state_q.ans;
    assign decode_out       = state_q.dec;
    assign device_reset_out = state_q.dev_rst;
    // Wait field ignored for table access when the enable bit is set
    assign table_wait_out   = state_q.dec.table_wait_apply ? bus_wait_count_in : 2'h0;
    assign port_g_pin5_out  = state_q.dec.port_g_pin5_is_input & port_g_pin5_in;
    assign port_c_pin1_ccp2_out = state_q.dec.ccp2_pin == cfg_fuse_pkg::CCP2_ON_PORT_C1;
    assign port_e_pin7_ccp2_out = state_q.dec.ccp2_pin == cfg_fuse_pkg::CCP2_ON_PORT_E7;
    assign port_b_pin3_ccp2_out = state_q.dec.ccp2_pin == cfg_fuse_pkg::CCP2_ON_PORT_B3;
    assign port_e_pwm_sel_out   = {4{state_q.dec.enh_pwm_on_port_e}};
    assign port_h_pwm_sel_out   = {4{~state_q.dec.enh_pwm_on_port_e}};
    assign debug_pin_sel_out    = {2{state_q.dec.debug_pins_dedicated}};

endmodule // config_fuse_decode_protect

`default_nettype wire

// file: testbench/cfg_fuse_asserts.sv
// Purpose: Port-level checks of the configuration decoder
// Assumes: Decode output lags the stored bytes by one enabled edge
// Notes:   Stable-decode guards keep the checks quiet across byte writes
`timescale 1ns/1ps
`default_nettype none
module cfg_fuse_asserts (
    input wire logic                      clk_in,
    input wire logic                      srst_in,
    input wire logic                      clk_en_in,
    input wire logic [21:0]               reg_addr_in,
    input wire logic                      reg_rd_in,
    input wire logic [7:0]                reg_rdata_out,
    input wire logic [1:0]                bus_wait_count_in,
    input wire logic                      master_reset_n_in,
    input wire logic                      port_g_pin5_in,
    input wire logic                      stack_fault_in,
    input wire cfg_fuse_pkg::cfg_decode_s decode_out,
    input wire logic [1:0]                table_wait_out,
    input wire logic                      device_reset_out,
    input wire logic                      port_g_pin5_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_wait_apply : assert property ($stable(decode_out) && $past(clk_en_in) |->
        $past(table_wait_out) == ($past(bus_wait_count_in) & {2{decode_out.table_wait_apply}}))
        else $error("table wait field not gated by wait enable");
    a_pin_input : assert property ($stable(decode_out) && $past(clk_en_in) |->
        $past(port_g_pin5_out) == ($past(port_g_pin5_in) & decode_out.port_g_pin5_is_input))
        else $error("general input pin value wrong");
    a_ccp2_e7_mode : assert property (decode_out.ccp2_pin == cfg_fuse_pkg::CCP2_ON_PORT_E7 |->
        decode_out.mode == cfg_fuse_pkg::MODE_MCU) else $error("port E7 outside controller mode");
    a_ccp2_b3_mode : assert property (decode_out.ccp2_pin == cfg_fuse_pkg::CCP2_ON_PORT_B3 |->
        decode_out.mode != cfg_fuse_pkg::MODE_MCU) else $error("port B3 in controller mode");
    a_stack_reset : assert property (stack_fault_in && clk_en_in &&
        decode_out.stack_fault_reset_enable ##1 $stable(decode_out) |-> device_reset_out)
        else $error("stack fault did not reset");
    a_pin_reset : assert property (!master_reset_n_in && clk_en_in &&
        decode_out.reset_pin_is_reset ##1 $stable(decode_out) |-> device_reset_out)
        else $error("reset pin did not reset");
    a_no_reset : assert property ((master_reset_n_in || !decode_out.reset_pin_is_reset) &&
        (!stack_fault_in || !decode_out.stack_fault_reset_enable) && clk_en_in
        ##1 $stable(decode_out) |-> !device_reset_out) else $error("reset without cause");
    a_id_read : assert property (reg_rd_in && clk_en_in &&
        reg_addr_in == cfg_fuse_pkg::OFF_ID_HIGH |=> reg_rdata_out == cfg_fuse_pkg::ID_PART_HIGH)
        else $error("part id byte wrong");
    a_hole_zero : assert property (reg_rd_in && clk_en_in &&
        reg_addr_in == 22'h30_0007 |=> reg_rdata_out == 8'h00) else $error("hole read not zero");
    c_reset : cover property (device_reset_out);
    c_port_e7 : cover property (decode_out.ccp2_pin == cfg_fuse_pkg::CCP2_ON_PORT_E7);
    c_wait : cover property (table_wait_out != 2'h0);
endmodule // cfg_fuse_asserts
bind config_fuse_decode_protect cfg_fuse_asserts u_cfg_fuse_asserts (.clk_in(clk_in),
    .srst_in(srst_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .bus_wait_count_in(bus_wait_count_in),
    .master_reset_n_in(master_reset_n_in), .port_g_pin5_in(port_g_pin5_in),
    .stack_fault_in(stack_fault_in), .decode_out(decode_out), .table_wait_out(table_wait_out),
    .device_reset_out(device_reset_out), .port_g_pin5_out(port_g_pin5_out));
`default_nettype wire

// file: testbench/cfg_table_agent.sv
// Purpose: Table read and write engine facing the protection logic
// Assumes: Request taken one edge after launch, answer stands one cycle
// Notes:   Released fields are inverted so a stale sample cannot match
`timescale 1ns/1ps
`default_nettype none
module cfg_table_agent (
    input  wire logic                      clk_in,
    input  wire cfg_fuse_pkg::access_ans_s ans_in,
    output logic [46:0]                    req_out
);
    initial req_out = '0;
    task automatic access(input logic w, input logic [21:0] t, x, input logic ee,
                          output cfg_fuse_pkg::access_ans_s a);
        @(posedge clk_in);
        req_out <= {1'b1, w, t, x, ee};
        @(posedge clk_in);
        req_out <= {1'b0, ~w, ~t, ~x, ~ee};
        #1 a = ans_in;
    endtask
endmodule // cfg_table_agent
`default_nettype wire

// file: testbench/tb.sv
// Purpose: Self-checking bench for the configuration decoder
// Assumes: Plain register port and a table access engine
// Notes:   Configuration lock is written last since only a reset undoes it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic        clk_in = 0, srst_in = 1, clk_en_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic [21:0] reg_addr_in = '0;
    logic [7:0]  reg_wdata_in = '0, reg_rdata_out;
    logic [1:0]  wait_in = 2'h2, table_wait_out, dbg;
    logic        pin = 1, fault = 0, dev_rst, pg_out, c1, e7, b3;
    logic [3:0]  pwm_e, pwm_h;
    logic [46:0] req;
    cfg_fuse_pkg::access_ans_s ans, last;
    cfg_fuse_pkg::cfg_decode_s decode_out;
    int          num_errors = 0, checks = 0;
    logic [21:0] offs [9] = '{22'h30_0004, 22'h30_0005, 22'h30_0006, 22'h30_0008,
        22'h30_0009, 22'h30_000a, 22'h30_000b, 22'h30_000c, 22'h30_000d};
    logic [7:0]  msk [9] = '{8'h83, 8'h83, 8'h85, 8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
    config_fuse_decode_protect #(.REVISION(5'h15), .HAS_BLOCK3(1'b1)) u_config_fuse_decode_protect
        (.clk_in(clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .bus_wait_count_in(wait_in), .master_reset_n_in(pin),
        .port_g_pin5_in(pin), .stack_fault_in(fault), .access_req_in(req), .access_ans_out(ans),
        .decode_out(decode_out), .table_wait_out(table_wait_out), .device_reset_out(dev_rst),
        .port_g_pin5_out(pg_out), .port_c_pin1_ccp2_out(c1), .port_e_pin7_ccp2_out(e7),
        .port_b_pin3_ccp2_out(b3), .port_e_pwm_sel_out(pwm_e), .port_h_pwm_sel_out(pwm_h),
        .debug_pin_sel_out(dbg));
    cfg_table_agent u_cfg_table_agent (.clk_in(clk_in), .ans_in(ans), .req_out(req));
    initial forever #25 clk_in = ~clk_in;
    task automatic wr(input logic [21:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [21:0] a, input logic [7:0] e);
        @(posedge clk_in);
        {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 `CHK(reg_rdata_out, e)
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic tacc(input logic w, input logic [21:0] t, x, input logic ee, e);
        u_cfg_table_agent.access(w, t, x, ee, last);
        `CHK(last.allow, e)
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        for (int i = 0; i < 9; i++) rd(offs[i], msk[i]);
        rd(22'h3f_ffff, cfg_fuse_pkg::ID_PART_HIGH);
        rd(22'h3f_fffe, {cfg_fuse_pkg::ID_PART_LOW[2:0], 5'h15});
        wr(22'h30_0007, 8'hff);
        rd(22'h30_0007, 8'h00);
        `CHK(table_wait_out, 2'h0)
        wr(22'h30_0006, 8'h81);
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 2; c++)
            begin
                wr(22'h30_0004, {6'h0, m[1:0]});
                wr(22'h30_0005, {7'h0, c[0]});
                settle();
                `CHK(decode_out.mode, m[1:0])
                `CHK({c1, e7, b3}, c[0] ? 3'b100 : (m == 3 ? 3'b010 : 3'b001))
                `CHK(table_wait_out, wait_in)
            end
        `CHK({pg_out, pwm_h, pwm_e}, 9'h1f0)
        @(posedge clk_in) pin <= 1'b0;
        settle();
        `CHK({dev_rst, pg_out}, 2'b00)
        wr(22'h30_0005, 8'h82);
        settle();
        `CHK({dev_rst, pg_out, pwm_e, pwm_h}, 10'h2f0)
        wr(22'h30_0004, 8'hfe);
        pin <= 1'b1;
        rd(22'h30_0004, 8'h82);
        wr(22'h30_0006, 8'h04);
        fault <= 1'b1;
        settle();
        `CHK({dev_rst, dbg, decode_out.low_volt_prog_enable}, 4'h7)
        wr(22'h30_0006, 8'h81);
        settle();
        `CHK({dev_rst, dbg, decode_out.low_volt_prog_enable}, 4'h8)
        @(posedge clk_in) {fault, clk_en_in} <= 2'b00;
        wr(22'h30_0006, 8'h00);
        clk_en_in <= 1'b1;
        rd(22'h30_0006, 8'h81);
        wr(22'h30_0008, 8'h0b);
        wr(22'h30_000c, 8'h0e);
        wr(22'h30_0009, 8'h40);
        wr(22'h30_000d, 8'h00);
        settle();
        tacc(0, 22'h00_8000, 22'h00_c000, 0, 0);
        `CHK(last.read_masked, 1'b1)
        tacc(0, 22'h00_8000, 22'h00_8100, 0, 1);
        tacc(0, 22'h00_0900, 22'h00_4000, 0, 0);
        tacc(0, 22'h00_4100, 22'h00_0900, 0, 1);
        tacc(0, 22'h00_0100, 22'h00_4000, 0, 0);
        tacc(0, 22'h00_0000, 22'h00_0000, 1, 0);
        wr(22'h30_000a, 8'h0d);
        wr(22'h30_000b, 8'h60);
        settle();
        tacc(1, 22'h00_5000, 22'h00_0000, 0, 0);
        tacc(1, 22'h00_9000, 22'h00_0000, 0, 1);
        tacc(1, 22'h00_0000, 22'h00_0000, 1, 0);
        tacc(1, 22'h00_0100, 22'h00_4000, 0, 1);
        tacc(1, 22'h30_0004, 22'h00_4000, 0, 1);
        wr(22'h30_000b, 8'h00);
        settle();
        tacc(1, 22'h00_0100, 22'h00_4000, 0, 0);
        tacc(1, 22'h30_0004, 22'h00_4000, 0, 0);
        wr(22'h30_0004, 8'h00);
        wr(22'h30_000b, 8'he0);
        rd(22'h30_0004, 8'h82);
        rd(22'h30_000b, 8'h00);
        @(posedge clk_in) srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(22'h30_000b, 8'he0);
        wrap_up();
    end
endmodule // tb
`undef CHK
`default_nettype wire
